// *** verilog/ise_pkg.sv ***
// Shared constants, types and reset values for the serial EEPROM slave port
package ise_pkg;

  // Core clock and programming time
  localparam int unsigned CLK_PERIOD_NS = 5;          // 200 MHz core clock
  localparam int unsigned PROG_TIME_NS = 5000000;     // Internal write cycle, plain default
  // Least time, so round up to whole cycles
  localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CW = 21;               // Width of the programming counter

  // Slave address decode
  localparam logic [3:0] DEV_CODE_DEF = 4'hA;         // Value is arbitrary, set per product
  localparam logic [2:0] BLK_RTC = 3'h0;              // Clock register block
  localparam logic [2:0] BLK_EE_LO = 3'h1;            // Lower nonvolatile block
  localparam logic [2:0] BLK_EE_HI = 3'h2;            // Upper nonvolatile block

  // Memory organisation
  localparam int unsigned EE_BYTES = 512;             // Two blocks of 256 bytes
  localparam int unsigned PAGE_BYTES = 8;             // Bytes per page
  localparam logic [3:0] BYTE_BITS = 4'h8;            // Bits per serial byte
  localparam logic [3:0] LAST_BIT = 4'h7;             // Index of last bit sent

  // Byte position within a transfer
  localparam logic [1:0] PH_ADDR = 2'h0;              // Slave address byte
  localparam logic [1:0] PH_WORD = 2'h1;              // Word address byte
  localparam logic [1:0] PH_DATA = 2'h2;              // Data bytes

  // Bus state machine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } ise_st_t;

  // Synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } ise_sync_t;

  // Idle bus is high, so the lines reset high
  localparam ise_sync_t SYNC_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, filt: 1'b1};

  // Slave core state
  typedef struct packed {
    ise_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [1:0] phase;
    logic rw;
    logic [2:0] blk;
    logic [7:0] ptr;
    logic sda_oe;
    logic acked;
    logic scl_d;
    logic sda_d;
    logic [7:0][7:0] pbuf;
    logic [7:0] pval;
    logic [5:0] ppage;
    logic busy;
    logic [PROG_CW-1:0] pcnt;
    logic [EE_BYTES-1:0][7:0] mem;
    logic rtc_we;
    logic [7:0] rtc_waddr;
    logic [7:0] rtc_wdata;
  } ise_core_t;

  localparam ise_core_t CORE_RST = '{st: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};

endpackage : ise_pkg

// *** verilog/ise_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module ise_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous line in, filtered level out
  input wire logic line_i,
  output logic line_f
);

  ise_pkg::ise_sync_t q; // Registered state
  ise_pkg::ise_sync_t n; // Next state

  // Stage one feeds only stage two; the filter moves once stages two and three agree
  always_comb begin
    n = q;
    n.s1 = line_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (q.s2 == q.s3) begin // Stable for two samples
      n.filt = q.s3;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= ise_pkg::SYNC_RST;
    end else begin
      q <= n;
    end
  end

  assign line_f = q.filt;

endmodule : ise_sync

`default_nettype wire

// *** verilog/ise_i2c_eeprom.sv ***
// Serial bus slave with 512-byte page-written memory and clock block port
`timescale 1ns/100ps
`default_nettype none

// Function
// - 512 bytes: two blocks, 8-byte pages
// - Page write wraps within same page
// - Data edge while clock high: START/STOP
// - Data changes only while clock low
// - Receiver drives ninth-clock acknowledge low
// - No acknowledge to memory while programming
// - After master NACK release data line
// - All bytes shifted MSB first
// - STOP or repeated START ends transfer
// - Address: code, block bits, direction
// - Block bit 1 forms the top address bit
// - Write: word address then data bytes
// - STOP launches internal write cycle
// - Page buffer commits after STOP only
// - Pointer increments after each byte
// - Over eight bytes roll within page
// - Clock block writes roll within block
// - Works at 100 and 400 kHz
// - Read: ack address, then send bytes
// - Block 0 clock, 1 lower, 2 upper
// - Clock block acknowledged while programming
// - Pointer keeps last address plus one
// - Reads wrap within the same block
module ise_i2c_eeprom #(
  parameter int unsigned PROG_CYCLES = ise_pkg::PROG_CYCLES, // Programming time in clocks
  parameter logic [3:0] DEV_CODE = ise_pkg::DEV_CODE_DEF     // Value is arbitrary
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Clock register block port
  output logic [7:0] rtc_raddr,
  input wire logic [7:0] rtc_rdata,
  output logic rtc_we,
  output logic [7:0] rtc_waddr,
  output logic [7:0] rtc_wdata,
  // Status
  output logic prog_busy
);

  ise_pkg::ise_core_t q; // Registered state
  ise_pkg::ise_core_t n; // Next state

  logic scl_f; // Filtered clock line
  logic sda_f; // Filtered data line
  logic scl_rise; // Clock rising edge
  logic scl_fall; // Clock falling edge
  logic start_c; // START or repeated START
  logic stop_c; // STOP
  logic blk_ok; // Address names a defined block
  logic ee_blk; // Address names a memory block
  logic [7:0] rd_byte; // Byte at the pointer
  logic [8:0] rd_idx; // Memory index for reads

  // Both lines pass four flops (three stages and the filter) before any edge logic
  ise_sync u_sync_scl (
    .clk(clk),
    .rst(rst),
    .line_i(scl_i),
    .line_f(scl_f)
  );

  ise_sync u_sync_sda (
    .clk(clk),
    .rst(rst),
    .line_i(sda_i),
    .line_f(sda_f)
  );

  // Edges of the filtered lines; a few core clocks of lag is far below a 400 kHz half period
  assign scl_rise = scl_f & ~q.scl_d;
  assign scl_fall = ~scl_f & q.scl_d;
  assign start_c = scl_f & q.scl_d & q.sda_d & ~sda_f; // Falling data, clock high
  assign stop_c = scl_f & q.scl_d & ~q.sda_d & sda_f; // Rising data, clock high

  // Address byte decode: block bits above the word address
  assign blk_ok = (q.sh[3:1] == ise_pkg::BLK_RTC) || (q.sh[3:1] == ise_pkg::BLK_EE_LO) ||
                  (q.sh[3:1] == ise_pkg::BLK_EE_HI);
  assign ee_blk = (q.sh[3:1] != ise_pkg::BLK_RTC);

  // Read source: block bit joins the pointer as the top address bit
  assign rd_idx = {q.blk[1], q.ptr};
  assign rd_byte = (q.blk == ise_pkg::BLK_RTC) ? rtc_rdata : q.mem[rd_idx];

  // Next-state logic for bus protocol, page buffer and programming cycle
  always_comb begin
    n = q;
    n.rtc_we = 1'b0;
    n.scl_d = scl_f;
    n.sda_d = sda_f;

    // Programming cycle: count, then commit only the bytes that arrived
    if (q.busy) begin
      if (q.pcnt == ise_pkg::PROG_CW'(PROG_CYCLES - 1)) begin
        n.busy = 1'b0;
        n.pcnt = '0;
        n.pval = '0;
        for (int i = 0; i < ise_pkg::PAGE_BYTES; i++) begin
          if (q.pval[i]) begin // Unwritten page bytes keep their value
            n.mem[{q.ppage, 3'(i)}] = q.pbuf[i]; // Page base is a multiple of eight
          end
        end
      end else begin
        n.pcnt = q.pcnt + 1'b1;
      end
    end

    if (start_c) begin
      // New transfer, also after a repeated START without release
      n.st = ise_pkg::ST_RX;
      n.cnt = '0;
      n.phase = ise_pkg::PH_ADDR;
      n.sda_oe = 1'b0;
      if (!q.busy) begin // A buffer not closed by STOP is dropped
        n.pval = '0;
      end
    end else if (stop_c) begin
      n.st = ise_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
      if (!q.busy && (q.pval != '0)) begin // STOP after memory data starts programming
        n.busy = 1'b1;
        n.pcnt = '0;
      end
    end else begin
      unique case (q.st)
        ise_pkg::ST_IDLE: begin
          // Bus ignored until START
        end
        ise_pkg::ST_RX: begin
          if (scl_rise) begin
            // Sample while clock high, MSB first
            n.sh = {q.sh[6:0], sda_f};
            n.cnt = q.cnt + 1'b1;
          end else if (scl_fall && (q.cnt == ise_pkg::BYTE_BITS)) begin
            n.cnt = '0;
            n.st = ise_pkg::ST_RX_ACK;
            n.sda_oe = 1'b1; // Ack driven low through ninth clock high phase
            unique case (q.phase)
              ise_pkg::PH_ADDR: begin
                n.blk = q.sh[3:1];
                n.rw = q.sh[0];
                n.phase = ise_pkg::PH_WORD;
                if ((q.sh[7:4] != DEV_CODE) || !blk_ok) begin // Not ours
                  n.st = ise_pkg::ST_IDLE;
                  n.sda_oe = 1'b0;
                end else if (q.busy && ee_blk) begin // Memory busy: no ack
                  n.st = ise_pkg::ST_IDLE;
                  n.sda_oe = 1'b0;
                end
                // Clock block still acknowledged while programming
              end
              ise_pkg::PH_WORD: begin
                // Word address loads the pointer and fixes the page
                n.ptr = q.sh;
                n.ppage = {q.blk[1], q.sh[7:3]};
                n.phase = ise_pkg::PH_DATA;
              end
              default: begin
                if (q.blk == ise_pkg::BLK_RTC) begin
                  // Clock block has no page limit, pointer wraps in block
                  n.rtc_we = 1'b1;
                  n.rtc_waddr = q.ptr;
                  n.rtc_wdata = q.sh;
                  n.ptr = q.ptr + 8'h01;
                end else begin
                  // Buffer the byte, later bytes overwrite earlier ones
                  n.pbuf[q.ptr[2:0]] = q.sh;
                  n.pval[q.ptr[2:0]] = 1'b1;
                  n.ptr = {q.ptr[7:3], q.ptr[2:0] + 3'h1}; // Wrap inside page
                end
              end
            endcase
          end
        end
        ise_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              // Address acknowledged, start sending at the pointer
              n.tx = rd_byte;
              n.sda_oe = ~rd_byte[7]; // Open drain: enable pulls low
              n.ptr = q.ptr + 8'h01; // Reads wrap within block
              n.st = ise_pkg::ST_TX;
            end else begin
              n.sda_oe = 1'b0;
              n.st = ise_pkg::ST_RX;
            end
          end
        end
        ise_pkg::ST_TX: begin
          if (scl_fall) begin
            // Next bit only after clock goes low
            if (q.cnt == ise_pkg::LAST_BIT) begin
              n.sda_oe = 1'b0; // Release for master's ack bit
              n.cnt = '0;
              n.st = ise_pkg::ST_TX_ACK;
            end else begin
              n.tx = {q.tx[6:0], 1'b0};
              n.sda_oe = ~q.tx[6];
              n.cnt = q.cnt + 1'b1;
            end
          end
        end
        ise_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            n.acked = ~sda_f; // Low means master wants more
          end else if (scl_fall) begin
            if (q.acked) begin
              n.tx = rd_byte;
              n.sda_oe = ~rd_byte[7];
              n.ptr = q.ptr + 8'h01;
              n.st = ise_pkg::ST_TX;
            end else begin
              // NACK: line stays released so master can STOP
              n.sda_oe = 1'b0;
              n.st = ise_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          n.st = ise_pkg::ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= ise_pkg::CORE_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs, all from flops except sda_o, which is tied low
  assign sda_o = 1'b0; // Open drain only ever pulls low
  assign sda_oe = q.sda_oe;
  assign rtc_raddr = q.ptr;
  assign rtc_we = q.rtc_we;
  assign rtc_waddr = q.rtc_waddr;
  assign rtc_wdata = q.rtc_wdata;
  assign prog_busy = q.busy;

endmodule : ise_i2c_eeprom

`default_nettype wire

// *** verification/ise_i2c_eeprom_assertions.sv ***
// Assertions on the slave port pins
`timescale 1ns/100ps
`default_nettype none
module ise_i2c_eeprom_assertions #(
  parameter int unsigned PROG_CYCLES = 20 // Write cycle, clocks
) (
  // Clock, reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Clock block
  input wire logic [7:0] rtc_raddr,
  input wire logic [7:0] rtc_rdata,
  input wire logic rtc_we,
  input wire logic [7:0] rtc_waddr,
  input wire logic [7:0] rtc_wdata,
  // Status
  input wire logic prog_busy
);
  // Helper state
  typedef struct packed {
    logic [31:0] bc; // Busy clocks
    logic [3:0] ss; // Clocks since STOP, saturating
    logic [7:0] wa; // Last clock-block address
    logic sm; // Earlier write in this transfer
    logic cd;
    logic dd;
  } ise_chk_t;
  ise_chk_t h_r, h_nxt;
  // Next state; pin conditions as sampled here
  always_comb begin
    h_nxt = h_r;
    h_nxt.cd = scl_i;
    h_nxt.dd = sda_i;
    h_nxt.bc = prog_busy ? h_r.bc + 32'h1 : 32'h0;
    if (h_r.ss != 4'hF) h_nxt.ss = h_r.ss + 4'h1;
    if (scl_i && h_r.cd && sda_i && !h_r.dd) h_nxt.ss = 4'h0; // STOP
    if (rtc_we) h_nxt.wa = rtc_waddr;
    if (rtc_we) h_nxt.sm = 1'b1;
    if (scl_i && h_r.cd && !sda_i && h_r.dd) h_nxt.sm = 1'b0; // START
  end
  // Idle lines at reset, so no false condition
  always_ff @(posedge clk or posedge rst) begin
    if (rst) h_r <= '{ss: 4'hF, cd: 1'b1, dd: 1'b1, default: '0};
    else h_r <= h_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence start_s; scl_i && sda_i ##1 scl_i && !sda_i; endsequence
  sequence stop_s; scl_i && !sda_i ##1 scl_i && sda_i; endsequence
  a_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("data drive changed with clock high");
  a_drain_low: assert property (sda_oe |-> !sda_o)
    else $error("data drive not low");
  a_start_quiet: assert property (start_s |=> !sda_oe [*8])
    else $error("drive during address byte");
  a_stop_quiet: assert property (stop_s |=> !sda_oe [*8])
    else $error("drive after stop");
  a_busy_len: assert property ($fell(prog_busy) |-> h_r.bc == PROG_CYCLES)
    else $error("write cycle length wrong");
  a_busy_cause: assert property ($rose(prog_busy) |-> h_r.ss <= 4'hC)
    else $error("write cycle without stop");
  a_rtc_pulse: assert property (rtc_we |=> !rtc_we [*8])
    else $error("clock write pulse too long");
  a_rtc_step: assert property (rtc_we && h_r.sm |-> rtc_waddr == h_r.wa + 8'h1)
    else $error("clock write address step wrong");
endmodule : ise_i2c_eeprom_assertions
bind ise_i2c_eeprom ise_i2c_eeprom_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .rtc_raddr(rtc_raddr), .rtc_rdata(rtc_rdata), .rtc_we(rtc_we), .rtc_waddr(rtc_waddr),
  .rtc_wdata(rtc_wdata), .prog_busy(prog_busy));
`default_nettype wire

// *** verification/ise_mst.sv ***
// Bus master model: drives clock and data, reads the wire
`timescale 1ns/100ps
`default_nettype none
module ise_mst (
  // Wire level
  input wire logic sda_w,
  // Driven lines, high when released
  output logic scl,
  output logic sda
);
  localparam int Q = 16; // Quarter of the 64 ns period
  // Idle bus, clock still outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // One bit, wire sampled mid-high
  task automatic bit_c(input logic b, output logic r);
    sda = b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda_w;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : bit_c
  // START or repeated START; off the core edge
  task automatic start_c();
    #1;
    sda = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : start_c
  // STOP
  task automatic stop_c();
    sda = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda = 1'b1;
    #(2 * Q);
  endtask : stop_c
  // Byte out, then acknowledge
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(d[i], r);
    bit_c(1'b1, r);
    a = !r;
  endtask : wbyte
  // Byte in; last one refused
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
    bit_c(last, r);
  endtask : rbyte
endmodule : ise_mst
`default_nettype wire

// *** verification/ise_i2c_eeprom_tb.sv ***
// Self-checking bench for the slave port
`timescale 1ns/100ps
`default_nettype none
module ise_i2c_eeprom_tb;
  localparam int unsigned PC = 400; // Short write cycle, room for polls
  localparam logic [3:0] DC = 4'h6; // Value is arbitrary
  logic clk;
  logic rst = 1'b1;
  logic scl, sda_m, sda_o, sda_oe, rtc_we, prog_busy;
  logic [7:0] rtc_raddr, rtc_rdata, rtc_waddr, rtc_wdata, ptr;
  wire logic sda_w;
  logic [7:0] mem [512]; // Expected memory
  logic [7:0] tab [256]; // Clock block contents
  logic [15:0] rq [$]; // Clock writes seen
  logic [15:0] xq [$]; // Clock writes expected
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Open drain with pull-up
  assign sda_w = sda_m & ~sda_oe;
  assign rtc_rdata = tab[rtc_raddr];
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ise_mst u_ise_mst (.sda_w(sda_w), .scl(scl), .sda(sda_m));
  ise_i2c_eeprom #(.PROG_CYCLES(PC), .DEV_CODE(DC)) u_ise_i2c_eeprom (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .rtc_raddr(rtc_raddr), .rtc_rdata(rtc_rdata), .rtc_we(rtc_we), .rtc_waddr(rtc_waddr),
    .rtc_wdata(rtc_wdata), .prog_busy(prog_busy));
  // Clock write log, run limit
  always @(posedge clk) begin
    if (rtc_we === 1'b1) rq.push_back({rtc_waddr, rtc_wdata});
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Byte out, acknowledge compared
  task automatic xb(input logic [7:0] d, input logic e);
    logic a;
    u_ise_mst.wbyte(d, a);
    chk(16'(a), 16'(e));
  endtask : xb
  // Bounded wait on the busy flag
  task automatic bw(input logic v, input int m);
    for (int k = 0; k < m && prog_busy !== v; k++) @(posedge clk);
  endtask : bw
  // Write n random bytes; memory blocks are polled while busy
  task automatic wr(input logic [2:0] b, input logic [7:0] w, input int n);
    logic [7:0] d;
    ptr = w;
    u_ise_mst.start_c();
    xb({DC, b, 1'b0}, 1'b1);
    xb(w, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      xb(d, 1'b1);
      if (b == 3'h0) begin
        xq.push_back({ptr, d});
        ptr = ptr + 8'h1;
      end else begin
        mem[{b[1], ptr}] = d;
        ptr = {ptr[7:3], ptr[2:0] + 3'h1};
      end
    end
    u_ise_mst.stop_c();
    bw(1'b1, 12);
    chk(16'(prog_busy), 16'(b != 3'h0));
    chk(16'(rq.size()), 16'(xq.size()));
    foreach (xq[i]) chk(rq[i], xq[i]);
    rq.delete();
    xq.delete();
    if (b != 3'h0) begin
      u_ise_mst.start_c();
      xb({DC, b, 1'b0}, 1'b0);
      u_ise_mst.start_c();
      xb({DC, 3'h0, 1'b0}, 1'b1);
      u_ise_mst.stop_c();
      chk(16'(prog_busy), 16'h1);
      bw(1'b0, 2000);
      chk(16'(prog_busy), 16'h0);
    end
  endtask : wr
  // Read n bytes, from w or from the kept pointer
  task automatic rd(input logic [2:0] b, input logic [7:0] w, input int n, input logic set);
    logic [7:0] d;
    if (set) begin
      u_ise_mst.start_c();
      xb({DC, b, 1'b0}, 1'b1);
      xb(w, 1'b1);
      ptr = w;
    end
    u_ise_mst.start_c();
    xb({DC, b, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_ise_mst.rbyte(i == n - 1, d);
      chk(16'(d), 16'(b == 3'h0 ? tab[ptr] : mem[{b[1], ptr}]));
      ptr = ptr + 8'h1;
    end
    chk(16'(sda_oe), 16'h0);
    chk(16'(sda_o), 16'h0);
    chk(16'(rtc_raddr), 16'(ptr));
    u_ise_mst.stop_c();
  endtask : rd
  initial begin
    void'($urandom(22));
    foreach (tab[i]) tab[i] = 8'($urandom);
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    // Foreign code, undefined blocks: no acknowledge until START
    for (int i = 2; i < 8; i++) begin
      u_ise_mst.start_c();
      xb({i == 2 ? ~DC : DC, 3'(i), 1'b0}, 1'b0);
      xb(8'h00, 1'b0);
      u_ise_mst.stop_c();
    end
    wr(3'h1, 8'h0D, 10);
    rd(3'h1, 8'h06, 12, 1'b1);
    wr(3'h2, 8'h00, 2);
    wr(3'h2, 8'hFE, 2);
    rd(3'h2, 8'hFE, 3, 1'b1);
    rd(3'h2, 8'h00, 1, 1'b0);
    wr(3'h0, 8'hFE, 3);
    rd(3'h0, 8'hFF, 2, 1'b1);
    final_report();
  end
endmodule : ise_i2c_eeprom_tb
`default_nettype wire
